// ===== design/timer_io_ch4_ch5_control.sv
/*
  control registers and input selection for timer channels 4 and 5, with
  an AXI4-Lite slave for the two control registers.
  assumes clock buses and event buses are one-cycle pulses on aclk; the three
  external pins are asynchronous and are synchronised here.
*/
// How it works
// - bits 3-4 pick the channel 3/4 event source: 0x the pin, 10 event bus 2, 11 event bus 3.
// - the channel 4 mode field decodes into seven modes, 11x being noise processing.
// - in either measure mode a capture always strobes the measure load, enable bit or not.
// - in measure clear with the enable bit low a capture does not reinitialise the counter.
// - channel 5 clock select 0xx takes the clock pin, 100..111 take clock buses 0..3.
// - channel 5 source 0x selects nothing, 10 its event pin, 11 event bus 3.
// - channel 5 mode sits in the top three bits of its byte with the same encoding.
`timescale 1ns/1ps
module timer_io_ch4_ch5_control (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite slave
  input  wire logic [tio_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [tio_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [tio_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [tio_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // shared buses, pulses on aclk
  input  wire logic [3:0]                    clock_bus,
  input  wire logic [3:0]                    input_event_bus,
  // asynchronous pins
  input  wire logic                          ch34_ext_event_pin,
  input  wire logic                          ext_clock_pin_1,
  input  wire logic                          ext_event_pin_7,
  // to the channel counters
  output tio_pkg::mode_flags_t               ch4_mode,
  output tio_pkg::mode_flags_t               ch5_mode,
  output logic                               ch3_event,
  output tio_pkg::chan_out_t                 timer_channel_4,
  output tio_pkg::chan_out_t                 timer_channel_5
);

  // control registers
  logic [tio_pkg::CTRL_W-1:0] channel4_control;
  logic [tio_pkg::CTRL_W-1:0] channel5_control;

  // field views
  wire logic [1:0] ch4_clock_select;
  wire logic       ch4_ext_input_enable;
  wire logic [1:0] ch3_ch4_source_select;
  wire logic [2:0] ch4_mode_select;
  wire logic [2:0] ch5_clock_select;
  wire logic [1:0] ch5_source_select;
  wire logic [2:0] ch5_mode_select;

  assign ch4_clock_select      = channel4_control[tio_pkg::CH4_CLK_LSB +: 2];
  assign ch4_ext_input_enable  = channel4_control[tio_pkg::CH4_EXT_BIT];
  assign ch3_ch4_source_select = channel4_control[tio_pkg::CH4_SRC_LSB +: 2];
  assign ch4_mode_select       = channel4_control[tio_pkg::CH4_MODE_LSB +: 3];
  assign ch5_clock_select      = channel5_control[tio_pkg::CH5_CLK_LSB +: 3];
  assign ch5_source_select     = channel5_control[tio_pkg::CH5_SRC_LSB +: 2];
  assign ch5_mode_select       = channel5_control[tio_pkg::CH5_MODE_LSB +: 3];

  // pin synchronisers
  wire logic ch34_pin_rise;
  wire logic clk_pin_rise;
  wire logic ev7_pin_rise;

  pin_edge_sync u_sync_ch34 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ch34_ext_event_pin),
    .rise    (ch34_pin_rise)
  );

  pin_edge_sync u_sync_clk1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_clock_pin_1),
    .rise    (clk_pin_rise)
  );

  pin_edge_sync u_sync_ev7 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_event_pin_7),
    .rise    (ev7_pin_rise)
  );

  // mode decoders
  tio_pkg::mode_flags_t ch4_flags;
  tio_pkg::mode_flags_t ch5_flags;

  mode_decode u_dec_ch4 (
    .code  (ch4_mode_select),
    .flags (ch4_flags)
  );

  mode_decode u_dec_ch5 (
    .code  (ch5_mode_select),
    .flags (ch5_flags)
  );

  // clock selection
  wire logic ch4_tick_sel;
  wire logic ch5_tick_sel;

  assign ch4_tick_sel = clock_bus[ch4_clock_select];
  assign ch5_tick_sel = ch5_clock_select[2] ? clock_bus[ch5_clock_select[1:0]] : clk_pin_rise;

  // enable/measure source selection
  wire logic ch34_event_sel;
  wire logic ch5_event_sel;

  assign ch34_event_sel = !ch3_ch4_source_select[1] ? ch34_pin_rise
                        : (ch3_ch4_source_select[0] ? input_event_bus[3] : input_event_bus[2]);
  assign ch5_event_sel  = !ch5_source_select[1] ? 1'b0
                        : (ch5_source_select[0] ? input_event_bus[3] : ev7_pin_rise);

  // on channel 4 the enable bit gates the event pulse in every mode and the reinit, but never the capture
  wire logic ch4_measuring;
  wire logic ch5_measuring;
  wire logic ch4_event_gated;
  wire logic ch4_capture;
  wire logic ch4_reinit;
  wire logic ch5_capture;
  wire logic ch5_reinit;

  assign ch4_measuring   = ch4_flags.measure_clear | ch4_flags.measure_free;
  assign ch5_measuring   = ch5_flags.measure_clear | ch5_flags.measure_free;
  assign ch4_event_gated = ch34_event_sel & ch4_ext_input_enable;
  assign ch4_capture     = ch4_measuring & ch34_event_sel;
  // without the enable bit the counter keeps counting through a capture
  assign ch4_reinit      = ch4_flags.measure_clear & ch34_event_sel & ch4_ext_input_enable;
  assign ch5_capture     = ch5_measuring & ch5_event_sel;
  assign ch5_reinit      = ch5_flags.measure_clear & ch5_event_sel;

  // bus decode
  wire logic aw_take;
  wire logic w_take;
  wire logic ar_take;
  wire logic aw_hit4;
  wire logic aw_hit5;
  wire logic ar_hit4;
  wire logic ar_hit5;
  wire logic wr_commit;
  wire logic wr_ok;

  logic [tio_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0]                 wr_byte;
  logic                       wr_lane;
  logic                       aw_held;
  logic                       w_held;

  tio_pkg::wr_state_t wr_state;
  tio_pkg::wr_state_t next_wr_state;
  tio_pkg::rd_state_t rd_state;
  tio_pkg::rd_state_t next_rd_state;

  assign aw_take   = s_axi_awvalid & s_axi_awready;
  assign w_take    = s_axi_wvalid & s_axi_wready;
  assign ar_take   = s_axi_arvalid & s_axi_arready;
  assign aw_hit4   = wr_addr[31:2] == tio_pkg::CH4_CTRL_ADDR[31:2];
  assign aw_hit5   = wr_addr[31:2] == tio_pkg::CH5_CTRL_ADDR[31:2];
  assign ar_hit4   = s_axi_araddr[31:2] == tio_pkg::CH4_CTRL_ADDR[31:2];
  assign ar_hit5   = s_axi_araddr[31:2] == tio_pkg::CH5_CTRL_ADDR[31:2];
  // both halves held, in either order
  assign wr_commit = (wr_state == tio_pkg::WR_IDLE) & aw_held & w_held;
  assign wr_ok     = aw_hit4 | aw_hit5;

  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      tio_pkg::WR_IDLE: if (wr_commit) next_wr_state = tio_pkg::WR_RESP;
      tio_pkg::WR_RESP: if (s_axi_bready) next_wr_state = tio_pkg::WR_IDLE;
      default:          next_wr_state = tio_pkg::WR_IDLE;
    endcase
  end

  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      tio_pkg::RD_IDLE: if (ar_take) next_rd_state = tio_pkg::RD_DATA;
      tio_pkg::RD_DATA: if (s_axi_rready) next_rd_state = tio_pkg::RD_IDLE;
      default:          next_rd_state = tio_pkg::RD_IDLE;
    endcase
  end

  // write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= '0;
      wr_byte       <= 8'h00;
      wr_lane       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held  <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
      end else if (wr_commit) begin
        w_held  <= 1'b0;
      end
      // ready stays low from a take until the write response is taken, so one item per channel
      s_axi_awready <= !aw_take & !aw_held & (wr_state == tio_pkg::WR_IDLE) & !wr_commit;
      s_axi_wready  <= !w_take & !w_held & (wr_state == tio_pkg::WR_IDLE) & !wr_commit;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= tio_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tio_pkg::RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; lane 0 carries the byte, upper lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel4_control <= tio_pkg::CTRL_RESET;
      channel5_control <= tio_pkg::CTRL_RESET;
    end else if (wr_commit & wr_lane) begin
      if (aw_hit4) channel4_control <= wr_byte;
      if (aw_hit5) channel5_control <= wr_byte;
    end
  end

  // read path
  wire logic [7:0] rd_byte;
  assign rd_byte = ar_hit4 ? channel4_control : (ar_hit5 ? channel5_control : 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state      <= tio_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= tio_pkg::RESP_OKAY;
    end else begin
      rd_state      <= next_rd_state;
      s_axi_arready <= (next_rd_state == tio_pkg::RD_IDLE) & !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= (ar_hit4 | ar_hit5) ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // registered channel outputs; mode changes mid-count are not guarded here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch4_mode        <= tio_pkg::MODE_FLAGS_RESET;
      ch5_mode        <= tio_pkg::MODE_FLAGS_RESET;
      ch3_event       <= 1'b0;
      timer_channel_4 <= '0;
      timer_channel_5 <= '0;
    end else begin
      ch4_mode                    <= ch4_flags;
      ch5_mode                    <= ch5_flags;
      ch3_event                   <= ch34_event_sel;
      timer_channel_4.count_tick  <= ch4_tick_sel;
      timer_channel_4.event_pulse <= ch4_event_gated;
      timer_channel_4.capture     <= ch4_capture;
      timer_channel_4.reinit      <= ch4_reinit;
      timer_channel_5.count_tick  <= ch5_tick_sel;
      timer_channel_5.event_pulse <= ch5_event_sel;
      timer_channel_5.capture     <= ch5_capture;
      timer_channel_5.reinit      <= ch5_reinit;
    end
  end

endmodule // timer_io_ch4_ch5_control

// ===== common/tio_pkg.sv
/*
  shared constants and types for the channel 4 / channel 5 timer control block.
  assumes a single 25 MHz clock and an AXI4-Lite register bus with 32-bit data.
*/
package tio_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // printed offsets are byte offsets that are not word aligned: kept as indices
  localparam logic [31:0] CH4_CTRL_INDEX = 32'h0080034a;
  localparam logic [31:0] CH5_CTRL_INDEX = 32'h0080034b;
  localparam logic [31:0] CH4_CTRL_ADDR  = {CH4_CTRL_INDEX[29:0], 2'h0};
  localparam logic [31:0] CH5_CTRL_ADDR  = {CH5_CTRL_INDEX[29:0], 2'h0};

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_W = 8;

  // channel 4 field layout
  localparam int CH4_CLK_LSB  = 0;
  localparam int CH4_EXT_BIT  = 2;
  localparam int CH4_SRC_LSB  = 3;
  localparam int CH4_MODE_LSB = 5;
  // channel 5 field layout
  localparam int CH5_CLK_LSB  = 0;
  localparam int CH5_SRC_LSB  = 3;
  localparam int CH5_MODE_LSB = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_SINGLE     = 3'h0,
    MODE_DELAYED    = 3'h1,
    MODE_CONTINUOUS = 3'h2,
    MODE_PWM        = 3'h3,
    MODE_MEAS_CLEAR = 3'h4,
    MODE_MEAS_FREE  = 3'h5,
    MODE_NOISE      = 3'h6,
    MODE_NOISE_ALT  = 3'h7
  } mode_t;

  typedef struct packed {
    logic single_shot;
    logic delayed_shot;
    logic continuous;
    logic pwm;
    logic measure_clear;
    logic measure_free;
    logic noise;
  } mode_flags_t;

  // mode outputs sit in single-shot while reset is held
  localparam mode_flags_t MODE_FLAGS_RESET = 7'h40;

  typedef struct packed {
    logic count_tick;
    logic event_pulse;
    logic capture;
    logic reinit;
  } chan_out_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_DATA = 2'h1
  } rd_state_t;

endpackage

// ===== design/pin_edge_sync.sv
/*
  two flip-flop synchroniser with a rising-edge pulse behind it.
  assumes the pin is asynchronous to aclk and held at least two periods.
*/
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      rise
);
  logic meta;
  logic stable;
  logic stable_d;

  // only the second stage reads meta
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
      rise     <= 1'b0;
    end else begin
      meta     <= pin;
      stable   <= meta;
      stable_d <= stable;
      rise     <= stable & ~stable_d;
    end
  end
endmodule // pin_edge_sync

// ===== design/mode_decode.sv
/*
  decodes a three-bit channel mode code into one-hot mode flags.
  assumes the code comes from a register on the same clock.
*/
`timescale 1ns/1ps
module mode_decode (
  input  wire logic [2:0]          code,
  output tio_pkg::mode_flags_t     flags
);
  tio_pkg::mode_t mode;

  assign mode = tio_pkg::mode_t'(code);

  always_comb begin
    flags = '0;
    case (mode)
      tio_pkg::MODE_SINGLE:     flags.single_shot   = 1'b1;
      tio_pkg::MODE_DELAYED:    flags.delayed_shot  = 1'b1;
      tio_pkg::MODE_CONTINUOUS: flags.continuous    = 1'b1;
      tio_pkg::MODE_PWM:        flags.pwm           = 1'b1;
      tio_pkg::MODE_MEAS_CLEAR: flags.measure_clear = 1'b1;
      tio_pkg::MODE_MEAS_FREE:  flags.measure_free  = 1'b1;
      tio_pkg::MODE_NOISE:      flags.noise         = 1'b1;
      tio_pkg::MODE_NOISE_ALT:  flags.noise         = 1'b1;
      default:                  flags.single_shot   = 1'b1;
    endcase
  end
endmodule // mode_decode

// ===== sim/timer_io_monitor.sv
/*
  checker for timer_io_ch4_ch5_control: strobe, mode and read-channel relations.
  assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ps
module timer_io_monitor (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic [3:0]      clock_bus,
  input wire logic            ext_clock_pin_1,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input tio_pkg::mode_flags_t ch4_mode,
  input tio_pkg::mode_flags_t ch5_mode,
  input wire logic            ch3_event,
  input tio_pkg::chan_out_t   timer_channel_4,
  input tio_pkg::chan_out_t   timer_channel_5
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // mode taken as stable over two cycles, so a write in flight cannot fire it
  property p_reinit(logic cap, logic mc, logic r);
    cap && mc && $past(mc) |-> r;
  endproperty
  AST_RESET_MODE: assert property ($rose(aresetn) |-> ch4_mode == 7'h40 && ch5_mode == 7'h40)
    else $error("mode not single-shot after reset");
  AST_ONE_MODE: assert property ($onehot(ch4_mode) && $onehot(ch5_mode))
    else $error("mode flags not one-hot");
  AST_TICK4: assert property (timer_channel_4.count_tick |-> $past(|clock_bus))
    else $error("ch4 tick without clock bus pulse");
  AST_TICK5: assert property (timer_channel_5.count_tick |-> $past(|clock_bus) || $past(ext_clock_pin_1, 2))
    else $error("ch5 tick without a source");
  AST_GATE4: assert property (timer_channel_4.event_pulse |-> ch3_event)
    else $error("ch4 event without selected source");
  // capture and mode flags leave the same edge, so no past value is needed
  AST_CAP4: assert property (timer_channel_4.capture |-> ch3_event && (ch4_mode.measure_clear || ch4_mode.measure_free))
    else $error("ch4 capture outside measure modes");
  AST_NOINIT4: assert property (timer_channel_4.reinit |-> timer_channel_4.capture && timer_channel_4.event_pulse)
    else $error("ch4 reinit without enabled capture");
  AST_INIT4: assert property (p_reinit(timer_channel_4.capture && timer_channel_4.event_pulse,
    ch4_mode.measure_clear, timer_channel_4.reinit)) else $error("ch4 capture did not reinit");
  AST_INIT5: assert property (p_reinit(timer_channel_5.capture, ch5_mode.measure_clear,
    timer_channel_5.reinit)) else $error("ch5 capture did not reinit");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_RHIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  COV_REINIT4: cover property (timer_channel_4.reinit);
  COV_CAP5: cover property (timer_channel_5.capture);
  COV_PIN5: cover property (timer_channel_5.count_tick && !$past(|clock_bus));
endmodule // timer_io_monitor

// ===== sim/far_side_model.sv
/*
  far side of the block: shared clock and event buses and the three pins.
  assumes requests are one-cycle pulses from the bench on aclk.
*/
`timescale 1ns/1ps
module far_side_model (
  input wire logic       aclk,
  input wire logic [3:0] clk_req,
  input wire logic [3:0] evt_req,
  input wire logic [2:0] pin_req,
  output logic [3:0]     clock_bus,
  output logic [3:0]     input_event_bus,
  output logic [2:0]     pins
);
  logic [1:0] hold [3];
  initial begin
    clock_bus = 4'h0;
    input_event_bus = 4'h0;
    hold = '{default: 2'h0};
  end
  // buses are single-cycle pulses; pins stay high three cycles to pass the synchroniser
  always @(posedge aclk) begin
    clock_bus <= clk_req;
    input_event_bus <= evt_req;
    for (int i = 0; i < 3; i++) begin
      hold[i] <= pin_req[i] ? 2'h3 : hold[i] - {1'h0, hold[i] != 2'h0};
    end
  end
  assign pins = {hold[2] != 2'h0, hold[1] != 2'h0, hold[0] != 2'h0};
endmodule // far_side_model

// ===== sim/timer_io_ch4_ch5_control_tb.sv
/*
  self-checking bench for timer_io_ch4_ch5_control with a far-side model.
  assumes 25 MHz aclk and register access over AXI4-Lite.
*/
`timescale 1ns/1ps
module timer_io_ch4_ch5_control_tb;
  localparam logic [31:0] A4 = tio_pkg::CH4_CTRL_ADDR;
  localparam logic [31:0] A5 = tio_pkg::CH5_CTRL_ADDR;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, s = 32'h4b;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ch3_event;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'h1, clock_bus, input_event_bus, clk_req = 4'h0, evt_req = 4'h0;
  logic [2:0] pin_req = 3'h0, pins;
  logic [7:0] r4, r5;
  logic [33:0] cq[$], rq[$], bq[$];
  tio_pkg::mode_flags_t ch4_mode, ch5_mode;
  tio_pkg::chan_out_t timer_channel_4, timer_channel_5;
  int n_errors = 0, compares = 0;

  always #20 aclk = ~aclk;

  far_side_model fs (.aclk, .clk_req, .evt_req, .pin_req, .clock_bus, .input_event_bus, .pins);
  timer_io_ch4_ch5_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_bus,
    .input_event_bus, .ch34_ext_event_pin(pins[0]), .ext_clock_pin_1(pins[1]), .ext_event_pin_7(pins[2]),
    .ch4_mode, .ch5_mode, .ch3_event, .timer_channel_4, .timer_channel_5);

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // {ch3 event, ch4 strobes, ch5 strobes} for one stimulus
  function automatic logic [8:0] expv(input logic [7:0] a, b, input logic [3:0] c, e, input logic [2:0] p);
    logic v4, v5, t5;
    v4 = a[4] ? e[a[3] ? 3 : 2] : p[0];
    v5 = b[4] & (b[3] ? e[3] : p[2]);
    t5 = b[2] ? c[b[1:0]] : p[1];
    return {v4, c[a[1:0]], v4 & a[2], v4 & (a[7:6] == 2'h2), v4 & a[2] & (a[7:5] == 3'h4),
            t5, v5, v5 & (b[7:6] == 2'h2), v5 & (b[7:5] == 3'h4)};
  endfunction

  function automatic logic [6:0] mf(input logic [2:0] m);
    return 7'h40 >> ((m == 3'h7) ? 3'h6 : m);
  endfunction

  task automatic chk(input logic [33:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back({32'h0, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  // rready comes a cycle late so the data must stand
  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  task automatic fire(input logic [3:0] c, e, input logic [2:0] p);
    logic [8:0] x;
    x = expv(r4, r5, c, e, p);
    if (x != 9'h0) cq.push_back({25'h0, x});
    @(posedge aclk);
    clk_req <= c;
    evt_req <= e;
    pin_req <= p;
    @(posedge aclk);
    clk_req <= 4'h0;
    evt_req <= 4'h0;
    pin_req <= 3'h0;
    repeat (8) @(posedge aclk);
    chk(34'h0, {2'h0, 32'(cq.size())});
  endtask

  always @(posedge aclk) begin
    if (aresetn && (ch3_event || |timer_channel_4 || |timer_channel_5))
      chk(cq.pop_front(), {25'h0, ch3_event, timer_channel_4, timer_channel_5});
    if (s_axi_rvalid && s_axi_rready) chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk(bq.pop_front(), {32'h0, s_axi_bresp});
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(A4, 8'h0, tio_pkg::RESP_OKAY);
    rd(A5, 8'h0, tio_pkg::RESP_OKAY);
    for (int n = 0; n < 32; n++) begin
      s = xs(s);
      r4 = {n[2:0], s[4:0]};
      r5 = {n[4:2], s[12:8]};
      // strobes have drained before the mode changes
      wr(A4, r4, tio_pkg::RESP_OKAY);
      wr(A5, r5, tio_pkg::RESP_OKAY);
      rd(A4, r4, tio_pkg::RESP_OKAY);
      rd(A5, r5, tio_pkg::RESP_OKAY);
      chk({20'h0, mf(r4[7:5]), mf(r5[7:5])}, {20'h0, ch4_mode, ch5_mode});
      fire(s[19:16], s[23:20], 3'h0);
      fire(4'h0, 4'h0, s[26:24]);
    end
    r4 = 8'h98;
    wr(A4, r4, tio_pkg::RESP_OKAY);
    fire(4'h0, 4'h8, 3'h0);
    r4 = 8'h9c;
    wr(A4, r4, tio_pkg::RESP_OKAY);
    fire(4'h0, 4'h8, 3'h0);
    wr(A4 + 32'h8, 8'h5a, tio_pkg::RESP_SLVERR);
    rd(A4 + 32'h8, 8'h0, tio_pkg::RESP_SLVERR);
    // a write without lane 0 is answered but must leave the byte alone
    s_axi_wstrb <= 4'h0;
    wr(A4, 8'h11, tio_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd(A4, r4, tio_pkg::RESP_OKAY);
    give_verdict;
  end
endmodule // timer_io_ch4_ch5_control_tb

bind timer_io_ch4_ch5_control timer_io_monitor mon (.aclk, .aresetn, .clock_bus, .ext_clock_pin_1, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ch4_mode, .ch5_mode, .ch3_event, .timer_channel_4, .timer_channel_5);
